// file: design/tsel_pkg.sv
// package for the tariff selector: offsets, fields, reset values, types
package tsel_pkg;
	localparam logic [7:0] TSEL_ADDR_CTRL = 8'h00;
	localparam logic [7:0] TSEL_ADDR_STATUS = 8'h04;
	localparam logic [7:0] TSEL_ADDR_SAVE = 8'h08;
	localparam logic [7:0] TSEL_ADDR_CMD = 8'h0c;
	localparam logic [7:0] TSEL_ADDR_SLOT = 8'h10;
	localparam logic [7:0] TSEL_ADDR_ACC = 8'h30;
	localparam int TSEL_NSLOT = 4;
	localparam logic [10:0] TSEL_MIN_PER_DAY = 11'h5a0;
	localparam logic [10:0] TSEL_MIN_PER_HOUR = 11'h03c;
	localparam logic [3:0] TSEL_MONTH_MIN = 4'h1;
	localparam logic [3:0] TSEL_MONTH_MAX = 4'hc;
	localparam logic [4:0] TSEL_DAY_MIN = 5'h01;
	localparam logic [4:0] TSEL_DAY_MAX = 5'h1f;
	localparam int TSEL_CTRL_MODE_LSB = 0;
	localparam int TSEL_CTRL_TWO_BIT = 4;
	localparam int TSEL_CTRL_ENC_BIT = 5;
	localparam int TSEL_CTRL_CNT_LSB = 8;
	localparam int TSEL_CMD_EN_BIT = 4;
	localparam logic [2:0] TSEL_CNT_RST = 3'h1;
	localparam logic [6:0] TSEL_MASK_ALL = 7'h7f;
	localparam logic [6:0] TSEL_MASK_WEEKDAY = 7'h1f;
	localparam logic [6:0] TSEL_MASK_WEEKEND = 7'h60;

	typedef enum logic [1:0] {
		TSEL_MODE_CMD = 2'b00,
		TSEL_MODE_TOD = 2'b01,
		TSEL_MODE_INPUT = 2'b10
	} tsel_mode_e;

	typedef enum logic [3:0] {
		TSEL_DAY_OFF = 4'h0,
		TSEL_DAY_EVERY = 4'h1,
		TSEL_DAY_WEEKDAY = 4'h2,
		TSEL_DAY_WEEKEND = 4'h3,
		TSEL_DAY_MON = 4'h4,
		TSEL_DAY_SUN = 4'ha
	} tsel_day_e;

	typedef enum logic {
		TSEL_BUS_IDLE = 1'b0,
		TSEL_BUS_ACK = 1'b1
	} tsel_bus_e;

	// one schedule slot, word 0 then word 1
	typedef struct packed {
		logic [3:0] day_type;
		logic [10:0] end_min;
		logic [10:0] start_min;
		logic [3:0] end_month;
		logic [4:0] end_day;
		logic [3:0] start_month;
		logic [4:0] start_day;
	} tsel_slot_s;

	typedef struct packed {
		logic [1:0] mode;
		logic two_inputs;
		logic second_enc;
		logic [2:0] count;
	} tsel_ctrl_s;

	typedef struct packed {
		logic [1:0] tariff;
		logic enable;
	} tsel_cmd_s;
endpackage

// file: design/tsel_top.sv
// tariff selector: command, time-of-day and input modes with an avalon slave
// Operation
// - tariff code is binary {input 2, input 1}, inactive 0, active 1.
// - input mode is refused while input 1 holds an exclusive association.
// - an exclusively associated input is never used for tariff selection.
// - inputs needed: one for one or two tariffs, two for three or four tariffs; second encoding gives one tariff on one input, three on two.
// - first encoding: 00 is first tariff, input 1 alone second tariff.
// - second encoding: 00 none, input 1 first tariff, input 2 second.
// - input mode takes the tariff only from present input status.
// - command mode applies the commanded tariff until another command.
// - time-of-day mode matches day type, time and date per slot.
// - weekday comes from the clock; february 29 is a valid date.
// - end minute is inclusive through second 59.
// - day types everyday, weekday, weekend, one weekday; only everyday wraps midnight.
// - months 1 to 12, days 1 to 31.
// - schedules are checked on save; overlapping periods raise conflict.
// - four independent time-of-day slots.
// - more than two tariffs only when input 2 is free.
// - tariff count is capped by the number of usable inputs.
// - a setting holds whether one or two inputs select the tariff.
// - start time equal to end time disables the slot.
// - same month needs start day before end day.
// - energy accumulates only into the active tariff's accumulator.
`timescale 1ns/1ps
`default_nettype none
module tsel_top
	import tsel_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic din1_in,
	input wire logic din2_in,
	input wire logic din1_exclusive_in,
	input wire logic din2_exclusive_in,
	input wire logic [4:0] rtc_hour_in,
	input wire logic [5:0] rtc_minute_in,
	input wire logic [3:0] rtc_month_in,
	input wire logic [4:0] rtc_day_in,
	input wire logic [2:0] rtc_weekday_in,
	input wire logic energy_pulse_in,
	output logic [1:0] active_tariff_out,
	output logic tariff_valid_out,
	output logic [3:0] acc_strobe_out,
	output logic conflict_out
);
	function automatic logic [6:0] day_mask(input logic [3:0] t);
		logic [6:0] m;
		m = 7'h00;
		case (t)
			TSEL_DAY_EVERY: m = TSEL_MASK_ALL;
			TSEL_DAY_WEEKDAY: m = TSEL_MASK_WEEKDAY;
			TSEL_DAY_WEEKEND: m = TSEL_MASK_WEEKEND;
			default: begin
				if (t >= TSEL_DAY_MON && t <= TSEL_DAY_SUN) begin
					m = 7'h01 << (t - TSEL_DAY_MON);
				end
			end
		endcase
		return m;
	endfunction

	// circular interval, both ends inclusive
	function automatic logic contains(input logic [10:0] s, input logic [10:0] e,
		input logic [10:0] x);
		return (s <= e) ? (x >= s && x <= e) : (x >= s || x <= e);
	endfunction

	function automatic logic [10:0] date_key(input logic [3:0] mo, input logic [4:0] d);
		return {2'b00, mo, d};
	endfunction

	function automatic logic slot_ok(input tsel_slot_s s);
		logic ok;
		ok = s.day_type != TSEL_DAY_OFF && day_mask(s.day_type) != 7'h00;
		ok = ok && s.start_min < TSEL_MIN_PER_DAY && s.end_min < TSEL_MIN_PER_DAY;
		ok = ok && s.start_min != s.end_min;
		ok = ok && (s.start_min < s.end_min || s.day_type == TSEL_DAY_EVERY);
		ok = ok && s.start_month >= TSEL_MONTH_MIN && s.start_month <= TSEL_MONTH_MAX;
		ok = ok && s.end_month >= TSEL_MONTH_MIN && s.end_month <= TSEL_MONTH_MAX;
		ok = ok && s.start_day >= TSEL_DAY_MIN && s.end_day >= TSEL_DAY_MIN;
		ok = ok && (s.start_month != s.end_month || s.start_day < s.end_day);
		return ok;
	endfunction

	function automatic logic slots_overlap(input tsel_slot_s a, input tsel_slot_s b);
		logic days;
		logic times;
		logic dates;
		days = (day_mask(a.day_type) & day_mask(b.day_type)) != 7'h00;
		times = contains(a.start_min, a.end_min, b.start_min) ||
			contains(b.start_min, b.end_min, a.start_min);
		dates = contains(date_key(a.start_month, a.start_day), date_key(a.end_month, a.end_day),
			date_key(b.start_month, b.start_day)) ||
			contains(date_key(b.start_month, b.start_day), date_key(b.end_month, b.end_day),
			date_key(a.start_month, a.start_day));
		return days && times && dates;
	endfunction

	tsel_bus_e bus_r, bus_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	tsel_ctrl_s ctrl_r, ctrl_nxt;
	tsel_cmd_s cmd_r, cmd_nxt;
	logic mode_err_r, mode_err_nxt;
	tsel_slot_s slot_r [TSEL_NSLOT];
	tsel_slot_s slot_nxt [TSEL_NSLOT];
	logic [3:0] saved_ok_r, saved_ok_nxt;
	logic conflict_r, conflict_nxt;
	logic [31:0] acc_r [TSEL_NSLOT];
	logic [31:0] acc_nxt [TSEL_NSLOT];
	logic [1:0] active_r, active_nxt;
	logic valid_r, valid_nxt;
	logic [3:0] strobe_r, strobe_nxt;
	logic [3:0] ok_w;
	logic [6:0] mask_w [TSEL_NSLOT];
	logic [10:0] cur_min;
	logic [10:0] cur_date;
	logic take;
	logic two_eff;
	logic [1:0] din_code;
	logic [2:0] cap_w;
	logic [2:0] wr_cap;
	logic [2:0] wr_cnt;
	logic wr_two;

	genvar g;
	generate
		for (g = 0; g < TSEL_NSLOT; g++) begin : g_ok
			assign ok_w[g] = slot_ok(slot_r[g]);
			assign mask_w[g] = day_mask(slot_r[g].day_type);
		end
	endgenerate

	assign cur_min = 11'(rtc_hour_in) * TSEL_MIN_PER_HOUR + 11'(rtc_minute_in);
	assign cur_date = date_key(rtc_month_in, rtc_day_in);
	assign take = (avs_read_in || avs_write_in) && bus_r == TSEL_BUS_ACK;
	assign two_eff = ctrl_r.two_inputs && !din2_exclusive_in;
	assign din_code = {din2_in && two_eff, din1_in};
	// first encoding: 2 or 4 tariffs, second: 1 or 3
	assign cap_w = two_eff ? (ctrl_r.second_enc ? 3'h3 : 3'h4)
		: (ctrl_r.second_enc ? 3'h1 : 3'h2);
	assign wr_two = avs_writedata_in[TSEL_CTRL_TWO_BIT] && !din2_exclusive_in;
	assign wr_cap = wr_two ? (avs_writedata_in[TSEL_CTRL_ENC_BIT] ? 3'h3 : 3'h4)
		: (avs_writedata_in[TSEL_CTRL_ENC_BIT] ? 3'h1 : 3'h2);
	assign wr_cnt = avs_writedata_in[TSEL_CTRL_CNT_LSB +: 3];

	// register bus and configuration
	always_comb begin
		bus_nxt = TSEL_BUS_IDLE;
		rdata_nxt = rdata_r;
		ctrl_nxt = ctrl_r;
		cmd_nxt = cmd_r;
		mode_err_nxt = mode_err_r;
		saved_ok_nxt = saved_ok_r;
		conflict_nxt = conflict_r;
		for (int i = 0; i < TSEL_NSLOT; i++) begin
			slot_nxt[i] = slot_r[i];
		end
		if ((avs_read_in || avs_write_in) && bus_r == TSEL_BUS_IDLE) begin
			bus_nxt = TSEL_BUS_ACK;
			rdata_nxt = 32'h0;
			case (avs_address_in)
				TSEL_ADDR_CTRL: rdata_nxt = {21'h0, ctrl_r.count, 2'h0, ctrl_r.second_enc,
					ctrl_r.two_inputs, 2'h0, ctrl_r.mode};
				TSEL_ADDR_STATUS: rdata_nxt = {20'h0, saved_ok_r, 3'h0, mode_err_r,
					conflict_r, valid_r, active_r};
				TSEL_ADDR_CMD: rdata_nxt = {27'h0, cmd_r.enable, 2'h0, cmd_r.tariff};
				default: begin
					for (int i = 0; i < TSEL_NSLOT; i++) begin
						if (avs_address_in == TSEL_ADDR_SLOT + 8'(8 * i)) begin
							rdata_nxt = {slot_r[i].day_type, 1'h0, slot_r[i].end_min,
								5'h0, slot_r[i].start_min};
						end
						if (avs_address_in == TSEL_ADDR_SLOT + 8'(8 * i + 4)) begin
							rdata_nxt = {14'h0, slot_r[i].end_month, slot_r[i].end_day,
								slot_r[i].start_month, slot_r[i].start_day};
						end
						if (avs_address_in == TSEL_ADDR_ACC + 8'(4 * i)) begin
							rdata_nxt = acc_r[i];
						end
					end
				end
			endcase
		end
		if (avs_write_in && take) begin
			case (avs_address_in)
				TSEL_ADDR_CTRL: begin
					if (avs_writedata_in[TSEL_CTRL_MODE_LSB +: 2] == TSEL_MODE_INPUT &&
						din1_exclusive_in) begin
						mode_err_nxt = 1'b1;
					end else if (avs_writedata_in[TSEL_CTRL_MODE_LSB +: 2] != 2'b11) begin
						ctrl_nxt.mode = avs_writedata_in[TSEL_CTRL_MODE_LSB +: 2];
						mode_err_nxt = 1'b0;
					end
					ctrl_nxt.two_inputs = wr_two;
					ctrl_nxt.second_enc = avs_writedata_in[TSEL_CTRL_ENC_BIT];
					ctrl_nxt.count = (wr_cnt == 3'h0) ? TSEL_CNT_RST
						: (wr_cnt > wr_cap) ? wr_cap : wr_cnt;
				end
				TSEL_ADDR_CMD: begin
					cmd_nxt.tariff = avs_writedata_in[1:0];
					cmd_nxt.enable = avs_writedata_in[TSEL_CMD_EN_BIT];
				end
				TSEL_ADDR_SAVE: begin
					saved_ok_nxt = ok_w;
					conflict_nxt = 1'b0;
					for (int i = 0; i < TSEL_NSLOT; i++) begin
						for (int j = i + 1; j < TSEL_NSLOT; j++) begin
							if (ok_w[i] && ok_w[j] && slots_overlap(slot_r[i], slot_r[j])) begin
								conflict_nxt = 1'b1;
							end
						end
					end
				end
				default: begin
					for (int i = 0; i < TSEL_NSLOT; i++) begin
						if (avs_address_in == TSEL_ADDR_SLOT + 8'(8 * i)) begin
							slot_nxt[i].day_type = avs_writedata_in[31:28];
							slot_nxt[i].end_min = avs_writedata_in[26:16];
							slot_nxt[i].start_min = avs_writedata_in[10:0];
							saved_ok_nxt[i] = 1'b0;
						end
						if (avs_address_in == TSEL_ADDR_SLOT + 8'(8 * i + 4)) begin
							slot_nxt[i].end_month = avs_writedata_in[17:14];
							slot_nxt[i].end_day = avs_writedata_in[13:9];
							slot_nxt[i].start_month = avs_writedata_in[8:5];
							slot_nxt[i].start_day = avs_writedata_in[4:0];
							saved_ok_nxt[i] = 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			bus_r <= TSEL_BUS_IDLE;
			rdata_r <= 32'h0;
			ctrl_r <= '{mode: TSEL_MODE_CMD, two_inputs: 1'b0, second_enc: 1'b0,
				count: TSEL_CNT_RST};
			cmd_r <= '0;
			mode_err_r <= 1'b0;
			saved_ok_r <= 4'h0;
			conflict_r <= 1'b0;
			for (int i = 0; i < TSEL_NSLOT; i++) begin
				slot_r[i] <= '0;
			end
		end else begin
			bus_r <= bus_nxt;
			rdata_r <= rdata_nxt;
			ctrl_r <= ctrl_nxt;
			cmd_r <= cmd_nxt;
			mode_err_r <= mode_err_nxt;
			saved_ok_r <= saved_ok_nxt;
			conflict_r <= conflict_nxt;
			for (int i = 0; i < TSEL_NSLOT; i++) begin
				slot_r[i] <= slot_nxt[i];
			end
		end
	end

	// tariff evaluation and accumulation
	always_comb begin
		active_nxt = 2'h0;
		valid_nxt = 1'b0;
		strobe_nxt = 4'h0;
		for (int i = 0; i < TSEL_NSLOT; i++) begin
			acc_nxt[i] = acc_r[i];
		end
		case (ctrl_r.mode)
			TSEL_MODE_CMD: begin
				active_nxt = cmd_r.tariff;
				valid_nxt = cmd_r.enable;
			end
			TSEL_MODE_TOD: begin
				for (int i = TSEL_NSLOT - 1; i >= 0; i--) begin
					if (saved_ok_r[i] && mask_w[i][rtc_weekday_in] &&
						contains(slot_r[i].start_min, slot_r[i].end_min, cur_min) &&
						contains(date_key(slot_r[i].start_month, slot_r[i].start_day),
						date_key(slot_r[i].end_month, slot_r[i].end_day), cur_date)) begin
						active_nxt = 2'(i);
						valid_nxt = 1'b1;
					end
				end
			end
			TSEL_MODE_INPUT: begin
				if (ctrl_r.second_enc) begin
					active_nxt = din_code - 2'h1;
					valid_nxt = din_code != 2'h0;
				end else begin
					active_nxt = din_code;
					valid_nxt = 1'b1;
				end
				if (din1_exclusive_in || {1'b0, active_nxt} >= ctrl_r.count ||
					{1'b0, active_nxt} >= cap_w) begin
					valid_nxt = 1'b0;
				end
			end
			default: begin
				valid_nxt = 1'b0;
			end
		endcase
		if (energy_pulse_in && valid_r) begin
			acc_nxt[active_r] = acc_r[active_r] + 32'h1;
			strobe_nxt[active_r] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			active_r <= 2'h0;
			valid_r <= 1'b0;
			strobe_r <= 4'h0;
			for (int i = 0; i < TSEL_NSLOT; i++) begin
				acc_r[i] <= 32'h0;
			end
		end else begin
			active_r <= active_nxt;
			valid_r <= valid_nxt;
			strobe_r <= strobe_nxt;
			for (int i = 0; i < TSEL_NSLOT; i++) begin
				acc_r[i] <= acc_nxt[i];
			end
		end
	end

	assign avs_readdata_out = rdata_r;
	assign avs_waitrequest_out = (bus_r != TSEL_BUS_ACK);
	assign active_tariff_out = active_r;
	assign tariff_valid_out = valid_r;
	assign acc_strobe_out = strobe_r;
	assign conflict_out = conflict_r;
endmodule
`default_nettype wire

// file: test/tsel_din_model.sv
// far-side model of the two digital input lines and their associations
`timescale 1ns/1ps
`default_nettype none
module tsel_din_model (
	input wire logic [1:0] level_in,
	input wire logic [1:0] excl_in,
	output logic din1_out,
	output logic din2_out,
	output logic ex1_out,
	output logic ex2_out
);
	// on is 1, off is 0, input 1 in bit 0
	assign din1_out = level_in[0];
	assign din2_out = level_in[1];
	assign ex1_out = excl_in[0];
	assign ex2_out = excl_in[1];
endmodule
`default_nettype wire

// file: test/tsel_chk.sv
// port checker for the tariff selector
`timescale 1ns/1ps
`default_nettype none
module tsel_chk
	import tsel_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic avs_waitrequest_out,
	input wire logic din1_in,
	input wire logic din2_in,
	input wire logic din1_exclusive_in,
	input wire logic din2_exclusive_in,
	input wire logic energy_pulse_in,
	input wire logic [1:0] active_tariff_out,
	input wire logic tariff_valid_out,
	input wire logic [3:0] acc_strobe_out,
	input wire logic conflict_out
);
	logic wr_acc, sv, is_cmd, in1, in2;
	logic [6:0] ctl_r;
	logic [6:0] ctl_nxt;
	assign wr_acc = avs_write_in && !avs_waitrequest_out;
	assign sv = wr_acc && avs_address_in == TSEL_ADDR_SAVE;
	// tracked count, encoding, two inputs, mode
	always_comb begin
		ctl_nxt = ctl_r;
		if (wr_acc && avs_address_in == TSEL_ADDR_CTRL) begin
			ctl_nxt[6:2] = {avs_writedata_in[10:8], avs_writedata_in[5],
				avs_writedata_in[4] && !din2_exclusive_in};
			if (avs_writedata_in[1:0] != 2'h3 && !(avs_writedata_in[1:0] == 2'h2 && din1_exclusive_in))
				ctl_nxt[1:0] = avs_writedata_in[1:0];
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (srst_in)
			ctl_r <= 7'h00;
		else
			ctl_r <= ctl_nxt;
	end
	assign is_cmd = ctl_r[1:0] == TSEL_MODE_CMD;
	assign in1 = ctl_r == 7'h46 && !din1_exclusive_in && !din2_exclusive_in;
	assign in2 = ctl_r == 7'h4e && !din1_exclusive_in && !din2_exclusive_in;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low longer than one cycle");
	chk_wait_cause: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
		else $error("waitrequest low without request");
	chk_wait_answer: assert property ((avs_read_in || avs_write_in) |-> ##[0:2] !avs_waitrequest_out)
		else $error("request not answered");
	chk_strobe_tariff: assert property (1'b1 |=> acc_strobe_out == (($past(energy_pulse_in)
		&& $past(tariff_valid_out)) ? 4'h1 << $past(active_tariff_out) : 4'h0))
		else $error("strobe does not match active tariff");
	chk_in_binary: assert property (in1 |=> tariff_valid_out
		&& active_tariff_out == {$past(din2_in), $past(din1_in)})
		else $error("first encoding decode wrong");
	chk_in_second: assert property (in2 |=> tariff_valid_out == ($past(din1_in) || $past(din2_in))
		&& (!tariff_valid_out || active_tariff_out == {$past(din2_in), $past(din1_in)} - 2'h1))
		else $error("second encoding decode wrong");
	chk_cmd_hold: assert property ((is_cmd && !wr_acc) ##1 is_cmd |=> $stable(active_tariff_out)
		&& $stable(tariff_valid_out))
		else $error("command tariff changed without command");
	chk_conflict_save: assert property ($changed(conflict_out) |-> $past(sv) || $past(sv, 2))
		else $error("conflict changed without save");
	cover property (in1 && din1_in && din2_in);
	cover property ($rose(conflict_out));
	cover property (acc_strobe_out != 4'h0);
endmodule
bind tsel_top tsel_chk chk_u (.sys_clk_in, .srst_in, .avs_address_in, .avs_read_in,
	.avs_write_in, .avs_writedata_in, .avs_waitrequest_out, .din1_in, .din2_in,
	.din1_exclusive_in, .din2_exclusive_in, .energy_pulse_in, .active_tariff_out,
	.tariff_valid_out, .acc_strobe_out, .conflict_out);
`default_nettype wire

// file: test/test_tariff_selector.sv
// self-checking bench for the tariff selector
`timescale 1ns/1ps
`default_nettype none
module test_tariff_selector;
	import tsel_pkg::*;
	logic sys_clk_in, srst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic [7:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, q;
	logic din1, din2, ex1, ex2, energy_pulse_in, tariff_valid_out, conflict_out;
	logic [1:0] lvl, exc, active_tariff_out;
	logic [3:0] acc_strobe_out, mo;
	logic [4:0] hr, dy;
	logic [5:0] mn;
	logic [2:0] wd;
	int mismatches, check_count;
	tsel_top dut_u (.sys_clk_in, .srst_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .din1_in(din1),
		.din2_in(din2), .din1_exclusive_in(ex1), .din2_exclusive_in(ex2), .rtc_hour_in(hr),
		.rtc_minute_in(mn), .rtc_month_in(mo), .rtc_day_in(dy), .rtc_weekday_in(wd),
		.energy_pulse_in, .active_tariff_out, .tariff_valid_out, .acc_strobe_out, .conflict_out);
	tsel_din_model line_u (.level_in(lvl), .excl_in(exc), .din1_out(din1), .din2_out(din2),
		.ex1_out(ex1), .ex2_out(ex2));
	initial begin
		sys_clk_in = 1'b0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 50);
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		if (avs_waitrequest_out !== 1'b0) begin
			mismatches++;
			give_verdict();
		end
		tick(1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic tar(input logic v, input logic [1:0] a);
		tick(3);
		chk("tariff", {29'h0, v, a}, {29'h0, tariff_valid_out, v ? active_tariff_out : a});
	endtask
	task automatic pulse(input logic [3:0] e);
		energy_pulse_in <= 1'b1;
		tick(1);
		energy_pulse_in <= 1'b0;
		tick(1);
		chk("strobe", {28'h0, e}, {28'h0, acc_strobe_out});
	endtask
	function automatic logic [31:0] w0(input logic [3:0] t, input logic [10:0] s,
		input logic [10:0] e);
		return {t, 1'b0, e, 5'h00, s};
	endfunction
	function automatic logic [31:0] w1(input logic [3:0] sm, input logic [4:0] sd,
		input logic [3:0] em, input logic [4:0] ed);
		return {14'h0, em, ed, sm, sd};
	endfunction
	task automatic slot(input int n, input logic [31:0] a, input logic [31:0] b);
		wr(TSEL_ADDR_SLOT + 8'(8 * n), a);
		wr(TSEL_ADDR_SLOT + 8'(8 * n + 4), b);
	endtask
	task automatic tod(input logic [4:0] h, input logic [5:0] m, input logic [2:0] w,
		input logic [3:0] o, input logic v, input logic [1:0] a);
		hr <= h;
		mn <= m;
		wd <= w;
		mo <= o;
		dy <= 5'h1d;
		tar(v, a);
	endtask
	initial begin
		srst_in = 1'b1;
		{avs_read_in, avs_write_in, energy_pulse_in} = 3'h0;
		avs_address_in = 8'h00;
		avs_writedata_in = 32'h0;
		{lvl, exc, hr, mn, wd} = 18'h0;
		mo = 4'h1;
		dy = 5'h01;
		mismatches = 0;
		check_count = 0;
		tick(4);
		srst_in <= 1'b0;
		rd(TSEL_ADDR_STATUS);
		chk("status", 32'h0, q);
		wr(TSEL_ADDR_CMD, 32'h12);
		tar(1'b1, 2'h2);
		pulse(4'h4);
		rd(TSEL_ADDR_ACC + 8'h08);
		chk("acc", 32'h1, q);
		wr(TSEL_ADDR_CMD, 32'h13);
		tick(30);
		tar(1'b1, 2'h3);
		wr(TSEL_ADDR_CMD, 32'h01);
		tar(1'b0, 2'h0);
		pulse(4'h0);
		$display("command test done");
		wr(TSEL_ADDR_CTRL, 32'h412);
		for (int i = 0; i < 4; i++) begin
			lvl <= 2'(i);
			tar(1'b1, 2'(i));
		end
		wr(TSEL_ADDR_CTRL, 32'h432);
		rd(TSEL_ADDR_CTRL);
		chk("count", 32'h3, {29'h0, q[10:8]});
		for (int i = 0; i < 4; i++) begin
			lvl <= 2'(i);
			tar(i != 0, 2'(i - 1));
		end
		exc <= 2'b10;
		wr(TSEL_ADDR_CTRL, 32'h412);
		rd(TSEL_ADDR_CTRL);
		chk("two_and_count", 32'h4, {28'h0, q[10:8], q[4]});
		lvl <= 2'b11;
		tar(1'b1, 2'h1);
		$display("input test done");
		wr(TSEL_ADDR_CTRL, 32'h0);
		exc <= 2'b01;
		wr(TSEL_ADDR_CTRL, 32'h2);
		rd(TSEL_ADDR_CTRL);
		chk("mode", 32'h0, {30'h0, q[1:0]});
		rd(TSEL_ADDR_STATUS);
		chk("mode_err", 32'h1, {31'h0, q[4]});
		exc <= 2'b00;
		$display("refusal test done");
		slot(0, w0(TSEL_DAY_EVERY, 11'h564, 11'h12b), w1(4'h1, 5'h01, 4'hc, 5'h1f));
		slot(1, w0(TSEL_DAY_MON, 11'h12c, 11'h563), w1(4'h2, 5'h01, 4'h2, 5'h1d));
		slot(2, w0(TSEL_DAY_EVERY, 11'h078, 11'h078), w1(4'h1, 5'h01, 4'hc, 5'h1f));
		slot(3, w0(TSEL_DAY_WEEKEND, 11'h000, 11'h59f), w1(4'h6, 5'h0f, 4'h6, 5'h0c));
		wr(TSEL_ADDR_SAVE, 32'h0);
		wr(TSEL_ADDR_CTRL, 32'h1);
		rd(TSEL_ADDR_STATUS);
		chk("slot_ok", 32'h3, {28'h0, q[11:8]});
		chk("conflict", 32'h0, {31'h0, q[3]});
		tod(5'h04, 6'h3b, 3'h0, 4'h2, 1'b1, 2'h0);
		tod(5'h05, 6'h00, 3'h0, 4'h2, 1'b1, 2'h1);
		tod(5'h16, 6'h3b, 3'h0, 4'h2, 1'b1, 2'h1);
		tod(5'h17, 6'h00, 3'h2, 4'h2, 1'b1, 2'h0);
		tod(5'h0c, 6'h00, 3'h1, 4'h2, 1'b0, 2'h0);
		tod(5'h0c, 6'h00, 3'h0, 4'h3, 1'b0, 2'h0);
		tod(5'h01, 6'h1e, 3'h5, 4'h6, 1'b1, 2'h0);
		$display("time of day test done");
		slot(2, w0(TSEL_DAY_EVERY, 11'h03c, 11'h078), w1(4'h1, 5'h01, 4'hc, 5'h1f));
		wr(TSEL_ADDR_SAVE, 32'h0);
		tick(2);
		chk("conflict", 32'h1, {31'h0, conflict_out});
		slot(2, w0(TSEL_DAY_OFF, 11'h03c, 11'h078), w1(4'h1, 5'h01, 4'hc, 5'h1f));
		wr(TSEL_ADDR_SAVE, 32'h0);
		tick(2);
		chk("conflict", 32'h0, {31'h0, conflict_out});
		rd(8'hfc);
		chk("unmapped", 32'h0, q);
		$display("conflict test done");
		give_verdict();
	end
endmodule
`default_nettype wire
